// ==== hdl/tpp_top.v ====
// Terminal-side payload port of one framer channel with its APB registers.
// Assumes the framer core shares pclk and hands over receive data when
// told, and that terminal pins are asynchronous to pclk.
`timescale 1ns/10ps
`include "tpp_consts.vh"
module tpp_top #(
    parameter RX_HALF = `TPP_RX_HALF,
    parameter NIBS_PER_FRAME = `TPP_NIBS_PER_FRAME
) (
    input wire pclk, // system clock
    input wire presetn, // async reset, low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output reg pslverr, // APB error
    input wire tx_ref_clock_in, // transmit reference clock
    input wire tx_serial_in, // serial data, or packet active
    input wire [3:0] tx_nibble_in, // transmit nibble
    output reg rx_out_clock, // receive output clock
    output reg rx_serial_out, // serial data, or idle flag
    output reg rx_frame_start_pulse, // first bit or nibble
    output reg rx_overhead_flag, // overhead bit or nibble
    output reg [3:0] rx_nibble_out, // nibble, or packet byte low
    output reg [3:0] rx_packet_byte_hi, // packet byte high
    output reg tx_nibble_boundary_mark, // last nibble, or good check
    input wire irq_n_in, // interrupt wire level
    output reg irq_n_out, // interrupt drive value
    output reg irq_n_oe, // interrupt drive enable
    input wire [3:0] core_rx_data, // core receive bits
    input wire core_rx_first, // core data starts frame
    input wire core_rx_oh, // core data is overhead
    input wire [7:0] core_pkt_byte, // core packet byte
    input wire core_pkt_idle, // core idle between packets
    input wire core_pkt_fcs_ok, // core good check pulse
    input wire core_irq_req, // core wants service
    output reg core_rx_take, // receive data taken
    output reg [3:0] core_tx_data, // sampled transmit data
    output reg core_tx_stb, // transmit data strobe
    output reg core_tx_pkt_active // packet in progress
);

////////////////////////////////////////////////////////////////////////
// Synchronisers.

wire [6:0] sync_out;
wire ref_s;
wire ser_s;
wire [3:0] nib_s;
wire irq_s;

tpp_sync2 #(
    .W(7)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({irq_n_in, tx_nibble_in, tx_serial_in, tx_ref_clock_in}),
    .dout(sync_out)
);

assign ref_s = sync_out[0];
assign ser_s = sync_out[1];
assign nib_s = sync_out[5:2];
assign irq_s = sync_out[6];

////////////////////////////////////////////////////////////////////////
// Registers.

reg [7:0] cfg_ff;
reg [7:0] ctrl_ff;
reg [15:0] fcnt_ff;
reg ref_d_ff;
reg [7:0] div_ff;
reg [15:0] nib_cnt_ff;

wire pkt_mode;
wire nib_mode;
wire local_time;
wire acc;
wire wr_ok;
wire hit_cfg;
wire hit_ctrl;
wire hit_stat;
wire [31:0] stat_word;

assign pkt_mode = ctrl_ff[`TPP_CTRL_PKT];
assign nib_mode = ctrl_ff[`TPP_CTRL_NIB];
assign local_time = cfg_ff[`TPP_CFG_LT0] | cfg_ff[`TPP_CFG_LT1];

assign hit_cfg = (paddr == `TPP_OFS_CFG);
assign hit_ctrl = (paddr == `TPP_OFS_CTRL);
assign hit_stat = (paddr == `TPP_OFS_STAT);
assign acc = psel & penable & ~pready;
assign wr_ok = psel & penable & pready & pwrite;

assign stat_word = {8'h00, fcnt_ff, 4'h0, rx_serial_out & pkt_mode,
    tx_nibble_boundary_mark, ~irq_s, local_time};

function [31:0] rd_mux;
    input [7:0] a;
    input [7:0] cfg;
    input [7:0] ctl;
    input [31:0] st;
    begin
        if (a == `TPP_OFS_CFG) begin
            rd_mux = {24'h000000, cfg};
        end else if (a == `TPP_OFS_CTRL) begin
            rd_mux = {24'h000000, ctl};
        end else if (a == `TPP_OFS_STAT) begin
            rd_mux = st;
        end else begin
            rd_mux = 32'h00000000;
        end
    end
endfunction

// The answer comes one cycle into the access phase.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end else begin
        pready <= acc;
        if (acc) begin
            prdata <= pwrite ? 32'h00000000 :
                rd_mux(paddr, cfg_ff, ctrl_ff, stat_word);
            pslverr <= ~(hit_cfg | hit_ctrl | hit_stat) |
                (pwrite & hit_stat);
        end else begin
            pslverr <= 1'b0;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_ff <= `TPP_CFG_RST;
        ctrl_ff <= `TPP_CTRL_RST;
    end else begin
        if (wr_ok && hit_cfg) begin
            cfg_ff <= pwdata[7:0];
        end
        if (wr_ok && hit_ctrl) begin
            ctrl_ff <= {6'h00, pwdata[1:0]};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Receive clock and receive pins.

wire rx_rise;
wire rx_half_end;

assign rx_half_end = (div_ff == RX_HALF[7:0] - 8'h01);
assign rx_rise = rx_half_end & ~rx_out_clock;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_ff <= 8'h00;
        rx_out_clock <= 1'b0;
    end else begin
        if (rx_half_end) begin
            div_ff <= 8'h00;
            rx_out_clock <= ~rx_out_clock;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
end

// Receive pins change together with the rising receive clock, except that packet mode clears the framing pins at once.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_serial_out <= 1'b0;
        rx_frame_start_pulse <= 1'b0;
        rx_overhead_flag <= 1'b0;
        rx_nibble_out <= 4'h0;
        rx_packet_byte_hi <= 4'h0;
        core_rx_take <= 1'b0;
        fcnt_ff <= 16'h0000;
    end else begin
        core_rx_take <= rx_rise & ~pkt_mode;
        if (rx_rise) begin
            if (pkt_mode) begin
                rx_nibble_out <= core_pkt_byte[3:0];
                rx_packet_byte_hi <= core_pkt_byte[7:4];
                rx_serial_out <= core_pkt_idle;
                rx_frame_start_pulse <= 1'b0;
                rx_overhead_flag <= 1'b0;
            end else if (nib_mode) begin
                rx_nibble_out <= core_rx_data;
                rx_packet_byte_hi <= 4'h0;
                rx_serial_out <= 1'b0;
                rx_frame_start_pulse <= core_rx_first;
                rx_overhead_flag <= core_rx_oh;
            end else begin
                rx_serial_out <= core_rx_data[0];
                rx_nibble_out <= 4'h0;
                rx_packet_byte_hi <= 4'h0;
                rx_frame_start_pulse <= core_rx_first;
                rx_overhead_flag <= core_rx_oh;
            end
            if (!pkt_mode && core_rx_first) begin
                fcnt_ff <= fcnt_ff + 16'h0001;
            end
        end
        // framing pins cleared at once
        // Packet mode clears them without waiting for a receive edge.
        if (pkt_mode) begin
            rx_frame_start_pulse <= 1'b0;
            rx_overhead_flag <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Transmit sampling.

wire ref_rise;
wire tx_edge;
wire last_nib;

assign ref_rise = ref_s & ~ref_d_ff;
assign tx_edge = local_time ? ref_rise : rx_rise;
assign last_nib = (nib_cnt_ff == NIBS_PER_FRAME[15:0] - 16'h0001);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ref_d_ff <= 1'b0;
        core_tx_data <= 4'h0;
        core_tx_stb <= 1'b0;
        core_tx_pkt_active <= 1'b0;
        nib_cnt_ff <= 16'h0000;
    end else begin
        ref_d_ff <= ref_s;
        core_tx_stb <= tx_edge & ~pkt_mode;
        if (tx_edge) begin
            if (pkt_mode) begin
                core_tx_pkt_active <= ser_s;
                core_tx_data <= 4'h0;
            end else if (nib_mode) begin
                core_tx_pkt_active <= 1'b0;
                core_tx_data <= nib_s;
                nib_cnt_ff <= last_nib ? 16'h0000 :
                    nib_cnt_ff + 16'h0001;
            end else begin
                core_tx_pkt_active <= 1'b0;
                core_tx_data <= {3'b000, ser_s};
            end
        end
        if (!nib_mode || pkt_mode) begin
            nib_cnt_ff <= 16'h0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Shared boundary pin and interrupt.

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_nibble_boundary_mark <= 1'b0;
        irq_n_out <= 1'b0;
        irq_n_oe <= 1'b0;
    end else begin
        if (pkt_mode) begin
            tx_nibble_boundary_mark <= core_pkt_fcs_ok;
        end else begin
            tx_nibble_boundary_mark <= nib_mode & last_nib;
        end
        irq_n_out <= 1'b0;
        irq_n_oe <= core_irq_req;
    end
end

endmodule

// ==== hdl/tpp_consts.vh ====
// Constants of the terminal payload port: register offsets, fields,
// reset values and timing counts. Included by the top design file and the bench files.
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH

`define TPP_OFS_CFG 8'h00
`define TPP_OFS_CTRL 8'h04
`define TPP_OFS_STAT 8'h08

`define TPP_CFG_RST 8'h00
`define TPP_CTRL_RST 8'h00

`define TPP_CFG_LT0 0
`define TPP_CFG_LT1 1
`define TPP_CTRL_PKT 0
`define TPP_CTRL_NIB 1

`define TPP_STAT_LT 0
`define TPP_STAT_IRQ 1
`define TPP_STAT_MARK 2
`define TPP_STAT_IDLE 3
`define TPP_STAT_FCNT 8

`define TPP_RX_HALF 4
`define TPP_NIBS_PER_FRAME 1176

`endif

// ==== hdl/tpp_sync2.v ====
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or clock from outside pclk.
`timescale 1ns/10ps
module tpp_sync2 #(
    parameter W = 1
) (
    input wire pclk, // system clock
    input wire presetn, // async reset, low
    input wire [W-1:0] din, // asynchronous levels
    output reg [W-1:0] dout // synchronised levels
);

reg [W-1:0] meta_ff;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_ff <= {W{1'b0}};
        dout <= {W{1'b0}};
    end else begin
        meta_ff <= din;
        dout <= meta_ff;
    end
end

endmodule

// ==== tb/tpp_chk_sva.sv ====
// Checker on the terminal payload port pins.
// Assumes the mode register is changed only through APB.
`timescale 1ns/10ps
`include "tpp_consts.vh"
module tpp_chk (
    input wire pclk, // clock
    input wire presetn, // reset
    input wire psel, // select
    input wire penable, // enable
    input wire pwrite, // write
    input wire pready, // ready
    input wire [7:0] paddr, // address
    input wire [31:0] pwdata, // data
    input wire rx_out_clock, // rx clock
    input wire rx_serial_out, // bit
    input wire rx_frame_start_pulse, // start
    input wire rx_overhead_flag, // overhead
    input wire [3:0] rx_nibble_out, // nibble
    input wire tx_nibble_boundary_mark, // mark
    input wire irq_n_out, // irq value
    input wire irq_n_oe, // irq enable
    input wire core_pkt_fcs_ok, // check
    input wire core_irq_req // request
);
    reg [1:0] ctl_ff;
    reg [3:0] wr_ff;
    wire wr_ctl = psel & penable & ~pready & pwrite & (paddr == `TPP_OFS_CTRL);
    wire quiet = (wr_ff == 4'h0);
    wire pkt = ctl_ff[0] & quiet;
    wire frm = ~ctl_ff[0] & quiet;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 2'h0;
            wr_ff <= 4'h0;
        end else begin
            wr_ff <= {wr_ff[2:0], wr_ctl};
            if (wr_ctl)
                ctl_ff <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_irq_on; core_irq_req |=> irq_n_oe && !irq_n_out; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not driven");
    property p_irq_off; !core_irq_req |=> !irq_n_oe; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq held");
    property p_fcs; pkt |-> tx_nibble_boundary_mark == $past(core_pkt_fcs_ok); endproperty
    a_fcs: assert property (p_fcs) else $error("check pulse wrong");
    property p_pkt; pkt |-> !rx_frame_start_pulse && !rx_overhead_flag; endproperty
    a_pkt: assert property (p_pkt) else $error("frame pins in packet mode");
    property p_fs; frm && $changed(rx_frame_start_pulse) |-> $rose(rx_out_clock); endproperty
    a_fs: assert property (p_fs) else $error("start off rx edge");
    property p_oh; frm && $changed(rx_overhead_flag) |-> $rose(rx_out_clock); endproperty
    a_oh: assert property (p_oh) else $error("overhead off rx edge");
    property p_nib; frm && ctl_ff[1] && $changed(rx_nibble_out) |-> $rose(rx_out_clock); endproperty
    a_nib: assert property (p_nib) else $error("nibble off rx edge");
    property p_ser; frm && !ctl_ff[1] && $changed(rx_serial_out) |-> $rose(rx_out_clock); endproperty
    a_ser: assert property (p_ser) else $error("serial off rx edge");
endmodule
bind tpp_top tpp_chk chk_u (.*);

// ==== tb/tpp_term.sv ====
// Terminal equipment model: reference clock and transmit data.
// Assumes the mark is seen on the falling reference edge.
`timescale 1ns/10ps
module tpp_term (
    input wire pkt, // packet mode
    input wire tx_nibble_boundary_mark, // frame mark
    output reg tx_ref_clock_in, // reference
    output wire tx_serial_in, // serial data
    output wire [3:0] tx_nibble_in // nibble data
);
    reg [3:0] seq_ff = 4'h0;
    initial begin
        tx_ref_clock_in = 1'b0;
        #3;
        forever #80 tx_ref_clock_in = ~tx_ref_clock_in;
    end
    always @(negedge tx_ref_clock_in)
        seq_ff <= tx_nibble_boundary_mark ? 4'h0 : seq_ff + 4'h1;
    assign tx_serial_in = pkt | seq_ff[0];
    assign tx_nibble_in = seq_ff;
endmodule

// ==== tb/terminal_payload_port_bench.sv ====
// Bench for tpp_top with the terminal model and a core feed.
// Assumes RX_HALF 2 and eight nibbles a frame.
`timescale 1ns/10ps
`include "tpp_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module terminal_payload_port_bench;
    reg pclk, presetn, psel, penable, pwrite, pkt;
    reg [7:0] paddr, core_pkt_byte;
    reg [31:0] pwdata, rd;
    reg [3:0] core_rx_data, cnt_ff;
    reg core_rx_first, core_rx_oh, core_pkt_idle, core_pkt_fcs_ok, core_irq_req;
    wire pready, pslverr, tx_ref_clock_in, tx_serial_in, rx_out_clock, rx_serial_out;
    wire [31:0] prdata;
    wire [3:0] tx_nibble_in, rx_nibble_out, rx_packet_byte_hi, core_tx_data;
    wire rx_frame_start_pulse, rx_overhead_flag, tx_nibble_boundary_mark, irq_n_out, irq_n_oe;
    wire core_rx_take, core_tx_stb, core_tx_pkt_active;
    wire irq_n_in = irq_n_oe ? 1'b0 : 1'b1;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    reg m;
    tpp_top #(.RX_HALF(2), .NIBS_PER_FRAME(8)) dut_u (.*);
    tpp_term term_u (.*);
    task apb(input bit w, input [7:0] a, input [31:0] d, input bit xe);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            miscompares++;
        rd = prdata;
        `CHK(pslverr, xe)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_regs;
        apb(0, `TPP_OFS_CFG, 0, 0);
        `CHK(rd, 32'h0)
        apb(1, `TPP_OFS_CFG, 32'h1A5, 0);
        apb(0, `TPP_OFS_CFG, 0, 0);
        `CHK(rd, 32'hA5)
        apb(0, 8'h0C, 0, 1);
        apb(1, `TPP_OFS_STAT, 0, 1);
        for (int i = 0; i < 4; i++) begin
            apb(1, `TPP_OFS_CFG, 8'hFC + i, 0);
            apb(0, `TPP_OFS_STAT, 0, 0);
            `CHK(rd[`TPP_STAT_LT], |i[1:0])
        end
    endtask
    task t_rx(input [1:0] md);
        apb(1, `TPP_OFS_CTRL, md, 0);
        repeat (2) @(posedge rx_out_clock);
        repeat (20) begin
            @(posedge rx_out_clock);
            #1;
            `CHK(rx_frame_start_pulse, core_rx_first)
            `CHK(rx_overhead_flag, core_rx_oh)
            `CHK(rx_serial_out, md[1] ? 1'b0 : core_rx_data[0])
            `CHK(rx_nibble_out, md[1] ? core_rx_data : 4'h0)
        end
    endtask
    task t_tx;
        @(posedge tx_nibble_boundary_mark);
        m = 1'b1;
        n = 0;
        repeat (2000) begin
            @(posedge pclk);
            if (core_tx_stb === 1'b1) begin
                n++;
                `CHK(core_tx_data, tx_nibble_in)
            end
            if (tx_nibble_boundary_mark === 1'b1 && m === 1'b0)
                break;
            m = tx_nibble_boundary_mark;
        end
        `CHK(n, 8)
    endtask
    task t_pkt;
        apb(1, `TPP_OFS_CTRL, 3, 0);
        {pkt, core_pkt_byte, core_pkt_idle, core_pkt_fcs_ok} <= {1'b1, 8'hC3, 2'b11};
        @(posedge pclk);
        core_pkt_fcs_ok <= 1'b0;
        n = 0;
        repeat (6) begin #1; n += tx_nibble_boundary_mark; @(posedge pclk); end
        #1;
        `CHK(n, 1)
        `CHK({rx_packet_byte_hi, rx_nibble_out}, 8'hC3)
        `CHK(rx_serial_out, 1'b1)
        `CHK(rx_frame_start_pulse, 1'b0)
        @(posedge tx_ref_clock_in);
        repeat (6) @(posedge pclk);
        `CHK(core_tx_pkt_active, 1'b1)
    endtask
    task t_irq;
        apb(0, `TPP_OFS_STAT, 0, 0);
        core_irq_req <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({irq_n_oe, irq_n_out}, 2'b10)
        apb(0, `TPP_OFS_STAT, 0, 0);
        `CHK(rd[`TPP_STAT_IRQ], 1'b1)
        core_irq_req <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(irq_n_oe, 1'b0)
    endtask
    task give_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Core side presents a new unit after each take.
    always @(posedge pclk) begin
        if (core_rx_take === 1'b1) begin
            cnt_ff <= cnt_ff + 4'h1;
            core_rx_data <= core_rx_data + 4'h5;
            core_rx_first <= (cnt_ff == 4'hF);
            core_rx_oh <= (cnt_ff[1:0] == 2'h2);
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, pkt, paddr, pwdata} = 0;
        {core_rx_data, cnt_ff, core_rx_first, core_rx_oh} = 0;
        {core_pkt_byte, core_pkt_idle, core_pkt_fcs_ok, core_irq_req} = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_rx(2'h0);
        t_rx(2'h2);
        t_tx;
        t_pkt;
        t_irq;
        give_verdict;
    end
endmodule
